// File: rtl/ptv_params.svh
`ifndef PTV_PARAMS_SVH
`define PTV_PARAMS_SVH
`define PTV_ADDR_CTRL 8'h00
`define PTV_ADDR_STATUS 8'h04
`define PTV_ADDR_BYPASS 8'h08
`define PTV_CTRL_RESET 4'h0
`define PTV_CLK_HZ 25000000
`define PTV_TICKS_PER_S 1000
`define PTV_SCRAM_HOLD_S 10
`define PTV_RESP_OKAY 2'b00
`define PTV_RESP_DECERR 2'b11
`endif

// File: rtl/ptv_pkg.sv
package ptv_pkg;
   typedef enum logic [3:0] {
      PTV_MODE_SHUTDOWN = 4'h1,
      PTV_MODE_REFUEL = 4'h2,
      PTV_MODE_STARTUP = 4'h4,
      PTV_MODE_RUN = 4'h8
   } ptv_mode_t;
endpackage

// File: rtl/ptv_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ptv_sync #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] agree;

   assign agree = ~(s2 ^ s3);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         dout <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= (s3 & agree) | (dout & ~agree);
      end
   end
endmodule
`default_nettype wire

// File: rtl/ptv_vote.sv
`timescale 1ns/1ns
`default_nettype none
module ptv_vote (
   input wire logic [3:0] trips,
   input wire logic [3:0] mask,
   output logic hit
);
   logic [3:0] live;
   logic [2:0] cnt;

   assign live = trips & ~mask;
   assign cnt = 3'(live[0]) + 3'(live[1]) + 3'(live[2]) + 3'(live[3]);
   assign hit = (cnt >= 3'h2);
endmodule
`default_nettype wire

// File: rtl/ptv_top.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ptv_params.svh"
module ptv_top #(
   parameter int unsigned TICK_CYCLES = `PTV_CLK_HZ / `PTV_TICKS_PER_S,
   parameter int unsigned HOLD_TICKS = `PTV_SCRAM_HOLD_S * `PTV_TICKS_PER_S
) (
   input wire logic aclk,
   input wire logic aresetn,
   // Sensor channel bistables, bit n is channel n
   input wire logic [3:0] rx_pres_hi,
   input wire logic [3:0] water_lvl_lo,
   input wire logic [3:0] drywell_pres_hi,
   input wire logic [3:0] steam_rad_hi,
   input wire logic [3:0] pool_temp_hi,
   input wire logic [3:0] isol_inboard_closed,
   input wire logic [3:0] isol_outboard_closed,
   input wire logic [3:0] rod_drive_chg_lo,
   input wire logic [3:0] turb_stop_closed,
   input wire logic [3:0] turb_fast_sol_closed,
   input wire logic [3:0] turbine_trip_oil_lo,
   input wire logic [3:0] rx_pres_below_byp,
   input wire logic [3:0] turb_pres_below_byp,
   // Flux monitor divisions
   input wire logic [3:0] power_range_flux_trip,
   input wire logic [3:0] source_range_flux_trip,
   // Keylocks
   input wire logic [3:0] chan_byp_key,
   input wire logic [3:0] div_byp_key,
   input wire logic [3:0] isol_byp_key,
   input wire logic [3:0] noncoinc_dis_key,
   input wire logic [3:0] rod_drive_byp_key,
   // Mode switch, one-hot shutdown/refuel/startup/run
   input wire logic [3:0] mode_sw,
   input wire logic [1:0] man_scram_pb,
   input wire logic [1:0] man_scram_arm,
   input wire logic man_reset_sw,
   input wire logic [3:0] div_manual_pb,
   input wire logic [3:0] div_reset_pb,
   // Outputs
   output logic [3:0] div_trip,
   output logic scram,
   output logic [1:0] load_trip,
   output logic [3:0] rod_withdraw_block,
   output logic [3:0] recirc_pump_trip,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int SW = 97;

   // Keep a held bypass, else grant the lowest request
   function automatic logic [3:0] ptv_grant(
      input logic [3:0] req,
      input logic [3:0] cur
   );
      logic [3:0] g;
      g = 4'h0;
      if (cur != 4'h0) begin
         g = cur & req;
      end else begin
         g = req & (~req + 4'h1);
      end
      return g;
   endfunction

   logic [SW-1:0] sync_out;
   logic [3:0] rxp_s;
   logic [3:0] lvl_s;
   logic [3:0] dw_s;
   logic [3:0] rad_s;
   logic [3:0] pool_s;
   logic [3:0] inb_s;
   logic [3:0] outb_s;
   logic [3:0] chg_s;
   logic [3:0] tsv_s;
   logic [3:0] sol_s;
   logic [3:0] oil_s;
   logic [3:0] rxp_low_s;
   logic [3:0] turb_low_s;
   logic [3:0] pr_s;
   logic [3:0] sr_s;
   logic [3:0] chan_req_s;
   logic [3:0] div_req_s;
   logic [3:0] isol_req_s;
   logic [3:0] ncd_s;
   logic [3:0] rod_req_s;
   logic [3:0] mode_s;
   logic [1:0] pb_s;
   logic [1:0] arm_s;
   logic mrst_s;
   logic [3:0] dman_s;
   logic [3:0] drst_s;

   ptv_sync #(.W(SW)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({rx_pres_hi, water_lvl_lo, drywell_pres_hi, steam_rad_hi,
            pool_temp_hi, isol_inboard_closed, isol_outboard_closed,
            rod_drive_chg_lo, turb_stop_closed, turb_fast_sol_closed,
            turbine_trip_oil_lo, rx_pres_below_byp, turb_pres_below_byp,
            power_range_flux_trip, source_range_flux_trip, chan_byp_key,
            div_byp_key, isol_byp_key, noncoinc_dis_key, rod_drive_byp_key,
            mode_sw, man_scram_pb, man_scram_arm, man_reset_sw,
            div_manual_pb, div_reset_pb}),
      .dout(sync_out)
   );

   assign {rxp_s, lvl_s, dw_s, rad_s, pool_s, inb_s, outb_s, chg_s, tsv_s,
           sol_s, oil_s, rxp_low_s, turb_low_s, pr_s, sr_s, chan_req_s,
           div_req_s, isol_req_s, ncd_s, rod_req_s, mode_s, pb_s, arm_s,
           mrst_s, dman_s, drst_s} = sync_out;

   // Mode decode; an invalid switch position applies no automatic bypass
   logic m_shut;
   logic m_ref;
   logic m_start;
   logic m_run;
   logic low3;
   always_comb begin
      m_shut = 1'b0;
      m_ref = 1'b0;
      m_start = 1'b0;
      m_run = 1'b0;
      case (mode_s)
         ptv_pkg::PTV_MODE_SHUTDOWN: begin
            m_shut = 1'b1;
         end
         ptv_pkg::PTV_MODE_REFUEL: begin
            m_ref = 1'b1;
         end
         ptv_pkg::PTV_MODE_STARTUP: begin
            m_start = 1'b1;
         end
         ptv_pkg::PTV_MODE_RUN: begin
            m_run = 1'b1;
         end
         default: begin
            m_run = 1'b0;
         end
      endcase
   end
   assign low3 = m_shut | m_ref | m_start;

   // Bypass interlocks
   logic [3:0] chan_byp;
   logic [3:0] div_byp;
   logic [3:0] isol_byp;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_byp <= 4'h0;
      end else begin
         chan_byp <= ptv_grant(chan_req_s, chan_byp);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_byp <= 4'h0;
      end else begin
         div_byp <= ptv_grant(div_req_s, div_byp);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         isol_byp <= 4'h0;
      end else if (chan_byp != 4'h0) begin
         isol_byp <= 4'h0;
      end else begin
         isol_byp <= ptv_grant(isol_req_s, isol_byp);
      end
   end

   // Vote table: 0 pres, 1 level, 2 drywell, 3 rad, 4 pool, 5 isol,
   // 6 charging, 7 stop valve, 8 fast closure, 9 power, 10 source, 11 scram
   logic [3:0] kb [0:11];
   logic [3:0] km [0:11];
   logic [11:0] kv;

   always_comb begin
      kb[0] = rxp_s;
      kb[1] = lvl_s;
      kb[2] = dw_s;
      kb[3] = rad_s;
      kb[4] = pool_s;
      kb[5] = inb_s | outb_s;
      kb[6] = chg_s;
      kb[7] = tsv_s;
      kb[8] = sol_s | oil_s;
      kb[9] = pr_s;
      kb[10] = sr_s;
      kb[11] = div_trip;
      for (int k = 0; k < 9; k++) begin
         km[k] = chan_byp;
      end
      km[5] = chan_byp | isol_byp | ({4{low3}} & rxp_low_s);
      km[7] = chan_byp | turb_low_s;
      km[8] = chan_byp | turb_low_s;
      km[9] = 4'h0;
      km[10] = {4{m_run}};
      km[11] = div_byp;
   end

   genvar gk;
   generate
      for (gk = 0; gk < 12; gk++) begin : g_vote
         ptv_vote u_vote (
            .trips(kb[gk]),
            .mask(km[gk]),
            .hit(kv[gk])
         );
      end
   endgenerate

   logic common_trip;
   assign common_trip = |kv[5:0] | kv[7] | kv[8] | kv[9] | kv[10];

   // Per-division trip causes
   logic [3:0] ctrl_test;
   logic [3:0] rod_byp;
   logic [3:0] nonco;
   logic [3:0] cause;
   genvar gd;
   generate
      for (gd = 0; gd < 4; gd++) begin : g_div
         assign rod_byp[gd] = rod_req_s[gd] & (m_shut | m_ref);
         assign nonco[gd] = (|pr_s | |sr_s) & ~m_run & ~(ncd_s[gd] & low3);
         assign cause[gd] = common_trip | nonco[gd] | dman_s[gd] |
                            ctrl_test[gd] | (kv[6] & ~rod_byp[gd]);
      end
   endgenerate

   // Millisecond enable
   logic [14:0] tick_cnt;
   logic tick;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 15'h0000;
         tick <= 1'b0;
      end else if (tick_cnt == 15'(TICK_CYCLES - 1)) begin
         tick_cnt <= 15'h0000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 15'h0001;
         tick <= 1'b0;
      end
   end

   logic [13:0] shut_cnt;
   logic shut_done;
   logic mode_scram;
   assign shut_done = (shut_cnt == 14'(HOLD_TICKS));
   assign mode_scram = m_shut & ~shut_done;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shut_cnt <= 14'h0000;
      end else if (!m_shut) begin
         shut_cnt <= 14'h0000;
      end else if (tick && !shut_done) begin
         shut_cnt <= shut_cnt + 14'h0001;
      end
   end

   // Manual scram latches, one per load division
   logic [1:0] man_latch;
   logic [1:0] man_set;
   assign man_set = (pb_s & arm_s) | {2{mode_scram}};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         man_latch <= 2'h0;
      end else if (man_set != 2'h0) begin
         man_latch <= man_latch | man_set;
      end else if (mrst_s && pb_s == 2'h0) begin
         man_latch <= 2'h0;
      end
   end

   // Full scram and post-scram reset inhibit
   logic full;
   logic full_d;
   logic [13:0] inh_cnt;
   logic inhibit;
   assign full = kv[11] | (&man_latch);
   assign inhibit = (inh_cnt != 14'h0000);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_d <= 1'b0;
         inh_cnt <= 14'h0000;
      end else begin
         full_d <= full;
         if (full && !full_d) begin
            inh_cnt <= 14'(HOLD_TICKS);
         end else if (tick && inhibit) begin
            inh_cnt <= inh_cnt - 14'h0001;
         end
      end
   end

   // Division seal-in; a live cause beats reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_trip <= 4'h0;
      end else begin
         for (int d = 0; d < 4; d++) begin
            if (cause[d]) begin
               div_trip[d] <= 1'b1;
            end else if (drst_s[d] && !inhibit) begin
               div_trip[d] <= 1'b0;
            end
         end
      end
   end

   // Registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scram <= 1'b0;
         load_trip <= 2'h0;
         rod_withdraw_block <= 4'h0;
         recirc_pump_trip <= 4'h0;
      end else begin
         scram <= full;
         load_trip <= man_latch | {2{kv[11]}};
         rod_withdraw_block <= rod_byp;
         recirc_pump_trip <= {4{kv[7] | kv[8]}};
      end
   end

   // AXI4-Lite write side
   logic aw_got;
   logic w_got;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
   assign s_axi_wready = ~w_got & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         ctrl_test <= `PTV_CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_got && w_got && !s_axi_bvalid) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `PTV_ADDR_CTRL) begin
               s_axi_bresp <= `PTV_RESP_OKAY;
               if (w_strb[0]) begin
                  ctrl_test <= w_data[3:0];
               end
            end else if (aw_addr == `PTV_ADDR_STATUS ||
                         aw_addr == `PTV_ADDR_BYPASS) begin
               s_axi_bresp <= `PTV_RESP_OKAY;
            end else begin
               s_axi_bresp <= `PTV_RESP_DECERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read side
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `PTV_RESP_OKAY;
         case (s_axi_araddr)
            `PTV_ADDR_CTRL: begin
               s_axi_rdata <= {28'h0000000, ctrl_test};
            end
            `PTV_ADDR_STATUS: begin
               s_axi_rdata <= {24'h000000, inhibit, man_latch, full, div_trip};
            end
            `PTV_ADDR_BYPASS: begin
               s_axi_rdata <= {16'h0000, rod_byp, isol_byp, div_byp, chan_byp};
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `PTV_RESP_DECERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: verification/ptv_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module ptv_top_chk #(
   parameter int unsigned TICK_CYCLES = 25000,
   parameter int unsigned HOLD_TICKS = 10000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] rx_pres_hi,
   input wire logic [3:0] turb_stop_closed,
   input wire logic [3:0] turb_pres_below_byp,
   input wire logic [3:0] chan_byp_key,
   input wire logic [3:0] mode_sw,
   input wire logic [1:0] man_scram_pb,
   input wire logic [1:0] man_scram_arm,
   input wire logic [3:0] div_reset_pb,
   input wire logic [3:0] div_trip,
   input wire logic scram,
   input wire logic [1:0] load_trip,
   input wire logic [3:0] rod_withdraw_block,
   input wire logic [3:0] recirc_pump_trip
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   trip_vote_a: assert property (($countones(rx_pres_hi) >= 2 && chan_byp_key == 4'h0)[*8] |-> div_trip == 4'hF)
      else $error("division trip missing on two channel vote");
   scram_vote_a: assert property ($countones(div_trip) >= 3 |-> ##[1:2] scram)
      else $error("scram missing with three division trips");
   run_block_a: assert property ((mode_sw == 4'h8)[*8] |-> rod_withdraw_block == 4'h0)
      else $error("withdraw block in run mode");
   recirc_vote_a: assert property
      (($countones(turb_stop_closed & ~turb_pres_below_byp) >= 2 && chan_byp_key == 4'h0)[*8]
      |-> recirc_pump_trip == 4'hF)
      else $error("recirculation trip missing");
   recirc_same_a: assert property (recirc_pump_trip == 4'h0 || recirc_pump_trip == 4'hF)
      else $error("recirculation trip differs between divisions");
   seal_hold_a: assert property ((div_trip[0] && !div_reset_pb[0])[*6] |=> div_trip[0])
      else $error("division seal-in dropped without reset");
   man_latch_a: assert property ((man_scram_pb[0] && man_scram_arm[0])[*8] |-> load_trip[0])
      else $error("load division not tripped while pushbutton held");
   scram_load_a: assert property ($rose(scram) |-> ##[0:1] load_trip == 2'b11)
      else $error("full scram without both load divisions");
   cover property (scram);
   cover property (rod_withdraw_block != 4'h0);
   cover property (recirc_pump_trip == 4'hF);
endmodule
bind ptv_top ptv_top_chk #(.TICK_CYCLES(TICK_CYCLES), .HOLD_TICKS(HOLD_TICKS)) ptv_top_chk_inst (.aclk, .aresetn,
   .rx_pres_hi, .turb_stop_closed, .turb_pres_below_byp, .chan_byp_key, .mode_sw, .man_scram_pb, .man_scram_arm,
   .div_reset_pb, .div_trip, .scram, .load_trip, .rod_withdraw_block, .recirc_pump_trip);
`default_nettype wire

// File: verification/ptv_field.sv
`timescale 1ns/1ns
`default_nettype none
module ptv_field (
   output logic [3:0] sens [15],
   output logic [1:0] man_scram_pb,
   output logic [1:0] man_scram_arm
);
   // Bistable levels stand until changed
   task set(input int i, input logic [3:0] v);
      sens[i] <= v;
   endtask
   task push(input logic [1:0] a, input logic [1:0] p);
      man_scram_arm <= a;
      man_scram_pb <= p;
   endtask
   task clr;
      foreach (sens[i]) begin
         sens[i] <= 4'h0;
      end
      push(2'b11, 2'b00);
   endtask
endmodule
`default_nettype wire

// File: verification/tb_protection_trip_voting_logic.sv
`timescale 1ns/1ns
`default_nettype none
module tb_protection_trip_voting_logic;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] sens [15];
   logic [1:0] man_scram_pb, man_scram_arm, load_trip, s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic [3:0] chan_byp_key = 4'h0, div_byp_key = 4'h0, isol_byp_key = 4'h0, noncoinc_dis_key = 4'h0;
   logic [3:0] rod_drive_byp_key = 4'h0, mode_sw = 4'h8, div_manual_pb = 4'h0, div_reset_pb = 4'h0;
   logic [3:0] div_trip, rod_withdraw_block, recirc_pump_trip;
   logic man_reset_sw = 1'b0;
   logic scram, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   int num_errors = 0;
   int check_count = 0;
   always #20 aclk = ~aclk;
   ptv_field ptv_field_inst (.sens, .man_scram_pb, .man_scram_arm);
   ptv_top #(.TICK_CYCLES(4), .HOLD_TICKS(5)) ptv_top_inst (.aclk, .aresetn, .rx_pres_hi(sens[0]),
      .water_lvl_lo(sens[1]), .drywell_pres_hi(sens[2]), .steam_rad_hi(sens[3]), .pool_temp_hi(sens[4]),
      .isol_inboard_closed(sens[5]), .isol_outboard_closed(sens[6]), .rod_drive_chg_lo(sens[7]),
      .turb_stop_closed(sens[8]), .turb_fast_sol_closed(sens[9]), .turbine_trip_oil_lo(sens[10]),
      .rx_pres_below_byp(sens[11]), .turb_pres_below_byp(sens[12]), .power_range_flux_trip(sens[13]),
      .source_range_flux_trip(sens[14]), .chan_byp_key, .div_byp_key, .isol_byp_key, .noncoinc_dis_key,
      .rod_drive_byp_key, .mode_sw, .man_scram_pb, .man_scram_arm, .man_reset_sw, .div_manual_pb, .div_reset_pb,
      .div_trip, .scram, .load_trip, .rod_withdraw_block, .recirc_pump_trip, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   task w(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            wr_resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task rp(input logic [3:0] m);
      div_reset_pb <= m;
      w(6);
      div_reset_pb <= 4'h0;
      w(6);
   endtask
   task rs;
      man_reset_sw <= 1'b1;
      w(6);
      man_reset_sw <= 1'b0;
      w(6);
   endtask
   task rst;
      aresetn <= 1'b0;
      ptv_field_inst.clr();
      {chan_byp_key, div_byp_key, rod_drive_byp_key, div_manual_pb, isol_byp_key, noncoinc_dis_key} <= 24'h0;
      mode_sw <= 4'h8;
      w(5);
      aresetn <= 1'b1;
      w(2);
   endtask
   task t_vote;
      rst();
      chk("div_trip", 32'h0, 32'(div_trip));
      ptv_field_inst.set(0, 4'h1);
      w(10);
      chk("div_trip", 32'h0, 32'(div_trip));
      ptv_field_inst.set(0, 4'h3);
      w(8);
      chk("div_trip", 32'hF, 32'(div_trip));
      chk("scram", 32'h1, 32'(scram));
      ptv_field_inst.set(0, 4'h0);
      rp(4'hF);
      chk("div_trip", 32'hF, 32'(div_trip));
      w(20);
      rp(4'hF);
      chk("div_trip", 32'h0, 32'(div_trip));
   endtask
   task t_chan;
      rst();
      chan_byp_key <= 4'h3;
      w(8);
      ptv_field_inst.set(0, 4'h3);
      w(10);
      chk("div_trip", 32'h0, 32'(div_trip));
      rd(8'h08);
      chk("chan_bypass", 32'h1, 32'(rd_data[3:0]));
      ptv_field_inst.set(0, 4'h7);
      w(10);
      chk("div_trip", 32'hF, 32'(div_trip));
   endtask
   task t_div;
      rst();
      div_manual_pb <= 4'h4;
      w(10);
      chk("div_trip", 32'h4, 32'(div_trip));
      rp(4'h4);
      chk("div_trip", 32'h4, 32'(div_trip));
      div_manual_pb <= 4'h0;
      w(6);
      rp(4'h4);
      chk("div_trip", 32'h0, 32'(div_trip));
      div_byp_key <= 4'h3;
      w(8);
      wr(8'h00, 32'h3, 4'hF);
      chk("bresp", 32'h0, 32'(wr_resp));
      w(10);
      chk("div_trip", 32'h3, 32'(div_trip));
      chk("scram", 32'h0, 32'(scram));
      rd(8'h08);
      chk("div_bypass", 32'h1, 32'(rd_data[7:4]));
      wr(8'h00, 32'h0, 4'h0);
      rd(8'h00);
      chk("ctrl", 32'h3, rd_data);
      wr(8'h10, 32'h0, 4'hF);
      chk("bresp", 32'h3, 32'(wr_resp));
      rd(8'h10);
      chk("rresp", 32'h3, 32'(rd_resp));
      chk("rdata", 32'h0, rd_data);
   endtask
   task t_man;
      rst();
      ptv_field_inst.push(2'b10, 2'b01);
      w(10);
      chk("load_trip", 32'h0, 32'(load_trip));
      ptv_field_inst.push(2'b11, 2'b01);
      w(10);
      chk("load_trip", 32'h1, 32'(load_trip));
      chk("scram", 32'h0, 32'(scram));
      rs();
      chk("load_trip", 32'h1, 32'(load_trip));
      ptv_field_inst.push(2'b11, 2'b00);
      w(6);
      rs();
      chk("load_trip", 32'h0, 32'(load_trip));
      ptv_field_inst.push(2'b11, 2'b11);
      w(10);
      chk("scram", 32'h1, 32'(scram));
   endtask
   task t_mode;
      rst();
      mode_sw <= 4'h1;
      w(10);
      chk("scram", 32'h1, 32'(scram));
      w(30);
      rs();
      chk("load_trip", 32'h0, 32'(load_trip));
      chk("scram", 32'h0, 32'(scram));
      noncoinc_dis_key <= 4'h1;
      ptv_field_inst.set(13, 4'h1);
      w(10);
      chk("div_trip", 32'hE, 32'(div_trip));
   endtask
   task t_isol;
      rst();
      mode_sw <= 4'h4;
      ptv_field_inst.set(11, 4'h1);
      ptv_field_inst.set(5, 4'h3);
      w(10);
      chk("div_trip", 32'h0, 32'(div_trip));
      isol_byp_key <= 4'h2;
      w(8);
      ptv_field_inst.set(11, 4'h0);
      w(10);
      chk("div_trip", 32'h0, 32'(div_trip));
      chan_byp_key <= 4'h4;
      w(10);
      rd(8'h08);
      chk("bypass", 32'h4, 32'(rd_data[15:0]));
      chk("div_trip", 32'hF, 32'(div_trip));
   endtask
   task t_rod;
      rst();
      mode_sw <= 4'h2;
      rod_drive_byp_key <= 4'h2;
      w(10);
      chk("rod_withdraw_block", 32'h2, 32'(rod_withdraw_block));
      ptv_field_inst.set(7, 4'h3);
      w(10);
      chk("div_trip", 32'hD, 32'(div_trip));
      rod_drive_byp_key <= 4'hF;
      w(20);
      rp(4'hF);
      chk("div_trip", 32'h0, 32'(div_trip));
      ptv_field_inst.set(7, 4'h0);
      mode_sw <= 4'h8;
      w(10);
      chk("rod_withdraw_block", 32'h0, 32'(rod_withdraw_block));
      ptv_field_inst.set(12, 4'h3);
      ptv_field_inst.set(8, 4'h3);
      w(10);
      chk("recirc_pump_trip", 32'h0, 32'(recirc_pump_trip));
      ptv_field_inst.set(12, 4'h0);
      w(10);
      chk("recirc_pump_trip", 32'hF, 32'(recirc_pump_trip));
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      t_vote();
      t_chan();
      t_div();
      t_man();
      t_mode();
      t_isol();
      t_rod();
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
